// ==== pmc_pkg.sv ====
// constants and carrier types shared by the program memory checksum port
// assumes one 200 MHz reference clock drives every flip-flop of the block
package pmc_pkg;

    // debug link register addresses, reset and unmapped read values, one byte each
    localparam logic [7:0] ADDR_HALT_CTL = 8'h02;
    localparam logic [7:0] ADDR_CKSUM0 = 8'ha9;
    localparam logic [7:0] ADDR_CKSUM1 = 8'haa;
    localparam logic [7:0] ADDR_CKSUM2 = 8'hab;
    localparam logic [7:0] ADDR_CKSUM3 = 8'hac;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // checksum address space
    localparam logic [7:0] BLOCK_LOW_FIRST = 8'h00;
    localparam logic [7:0] BLOCK_LOW_LAST = 8'hff;
    localparam logic [15:0] MEM_START = 16'h0000;
    localparam int BLOCK_BYTES = 256;
    localparam int MEM_BYTES_DEF = 8192;

    // polynomials and seeds, arbitrary plain defaults
    localparam logic [31:0] POLY16_DEF = 32'h0000_1021;
    localparam logic [31:0] POLY32_DEF = 32'h04c1_1db7;
    localparam logic [31:0] INIT16_DEF = 32'h0000_0000;
    localparam logic [31:0] INIT32_DEF = 32'hffff_ffff;

    // link timing, times in ns and derived cycle counts
    localparam int CLK_PERIOD_NS = 5;
    localparam int LINK_IDLE_NS = 200;
    localparam int LINK_IDLE_CYC = (LINK_IDLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PIN_RESET_NS = 20000;
    localparam int PIN_RESET_CYC = (PIN_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // frame layout: write flag, eight address bits, eight data bits
    localparam int FRAME_BITS = 17;
    localparam int ADDR_BITS_END = 8;

    typedef struct packed {
        logic wr;
        logic [7:0] addr;
        logic [7:0] data;
    } pmc_req_type;

    typedef struct packed {
        logic start_block;
        logic start_full;
        logic [7:0] page;
    } pmc_cmd_type;

    typedef enum logic [2:0] {
        ENG_IDLE = 3'b001,
        ENG_RUN = 3'b010,
        ENG_DRAIN = 3'b100
    } pmc_eng_state_type;

endpackage : pmc_pkg

// ==== pmc_crc_engine.sv ====
// checksum engine walking program memory one byte per clock
// assumes a memory with one cycle read latency on the same clock
`timescale 1ns/1ps
module pmc_crc_engine #(
    parameter int MEM_BYTES = pmc_pkg::MEM_BYTES_DEF,
    parameter logic [31:0] POLY16 = pmc_pkg::POLY16_DEF,
    parameter logic [31:0] POLY32 = pmc_pkg::POLY32_DEF,
    parameter logic [31:0] INIT16 = pmc_pkg::INIT16_DEF,
    parameter logic [31:0] INIT32 = pmc_pkg::INIT32_DEF
) (
    input wire logic i_ref_clk,
    input wire logic i_reset_n,
    input wire pmc_pkg::pmc_cmd_type i_cmd,
    input wire logic [7:0] i_mem_data,
    output logic [15:0] o_mem_addr,
    output logic o_mem_rd,
    output logic o_busy,
    output logic o_done,
    output logic o_wide,
    output logic [31:0] o_result
);
    localparam logic [15:0] MEM_LAST = 16'(MEM_BYTES - 1);

    pmc_pkg::pmc_eng_state_type state_ff;
    logic [15:0] last_ff;
    logic vld_ff;
    logic [16:0] rd_cnt_ff;

    // msb-first bit serial update, eight bits per call
    function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d,
                                             input logic wide, input logic [31:0] poly);
        logic [31:0] r;
        logic fb;
        r = c;
        for (int i = 7; i >= 0; i--) begin
            fb = (wide ? r[31] : r[15]) ^ d[i];
            r = {r[30:0], 1'b0} ^ (fb ? poly : 32'h0000_0000);
            if (!wide) begin
                r[31:16] = 16'h0000;
            end
        end
        return r;
    endfunction : crc_byte

    // sequencer: address walk and done pulse
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_ff <= pmc_pkg::ENG_IDLE;
            o_mem_addr <= pmc_pkg::MEM_START;
            last_ff <= pmc_pkg::MEM_START;
            o_mem_rd <= 1'b0;
            o_wide <= 1'b0;
            o_done <= 1'b0;
        end else begin
            o_done <= 1'b0;
            unique case (state_ff)
                pmc_pkg::ENG_IDLE: begin
                    if (i_cmd.start_block) begin
                        o_mem_addr <= {i_cmd.page, pmc_pkg::BLOCK_LOW_FIRST};
                        last_ff <= {i_cmd.page, pmc_pkg::BLOCK_LOW_LAST};
                        o_wide <= 1'b0;
                        o_mem_rd <= 1'b1;
                        state_ff <= pmc_pkg::ENG_RUN;
                    end else if (i_cmd.start_full) begin
                        o_mem_addr <= pmc_pkg::MEM_START;
                        last_ff <= MEM_LAST;
                        o_wide <= 1'b1;
                        o_mem_rd <= 1'b1;
                        state_ff <= pmc_pkg::ENG_RUN;
                    end
                end
                pmc_pkg::ENG_RUN: begin
                    if (o_mem_addr == last_ff) begin
                        o_mem_rd <= 1'b0;
                        state_ff <= pmc_pkg::ENG_DRAIN;
                    end else begin
                        o_mem_addr <= o_mem_addr + 16'h0001;
                    end
                end
                pmc_pkg::ENG_DRAIN: begin
                    o_done <= 1'b1;
                    state_ff <= pmc_pkg::ENG_IDLE;
                end
            endcase
        end
    end

    // accumulator folds each byte the cycle after its read
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            vld_ff <= 1'b0;
            o_result <= 32'h0000_0000;
        end else begin
            vld_ff <= o_mem_rd;
            if (state_ff == pmc_pkg::ENG_IDLE && i_cmd.start_block) begin
                o_result <= INIT16;
            end else if (state_ff == pmc_pkg::ENG_IDLE && i_cmd.start_full) begin
                o_result <= INIT32;
            end else if (vld_ff) begin
                o_result <= crc_byte(o_result, i_mem_data, o_wide, o_wide ? POLY32 : POLY16);
            end
        end
    end

    assign o_busy = (state_ff != pmc_pkg::ENG_IDLE);

    // helper count of reads issued per run
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rd_cnt_ff <= 17'h0_0000;
        end else if (state_ff == pmc_pkg::ENG_IDLE) begin
            rd_cnt_ff <= 17'h0_0000;
        end else if (o_mem_rd) begin
            rd_cnt_ff <= rd_cnt_ff + 17'h0_0001;
        end
    end

    a_block_length: assert property (
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        (state_ff == pmc_pkg::ENG_DRAIN && !o_wide) |-> rd_cnt_ff == 17'(pmc_pkg::BLOCK_BYTES))
        else $error("block checksum did not read exactly one block");
    a_block_start_addr: assert property (
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        (state_ff == pmc_pkg::ENG_IDLE && i_cmd.start_block)
        |=> o_mem_addr == {$past(i_cmd.page), pmc_pkg::BLOCK_LOW_FIRST} && o_mem_rd)
        else $error("block checksum start address wrong");
    a_full_start_addr: assert property (
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        (state_ff == pmc_pkg::ENG_IDLE && i_cmd.start_full && !i_cmd.start_block)
        |=> o_mem_addr == pmc_pkg::MEM_START && o_wide && o_mem_rd)
        else $error("full checksum start address wrong");
    // whole-memory length judged from the read counter, the run is too long for a delay range
    a_full_length: assert property (
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        (state_ff == pmc_pkg::ENG_DRAIN && o_wide) |-> rd_cnt_ff == 17'(MEM_BYTES))
        else $error("full checksum did not read the whole memory");

endmodule : pmc_crc_engine

// ==== pmc_crc_debug_port.sv ====
// debug link slave with the four checksum registers and the halt control
// assumes link pins are asynchronous; memory and core run on i_ref_clk
`timescale 1ns/1ps

module pmc_crc_debug_port #(
    parameter int MEM_BYTES = pmc_pkg::MEM_BYTES_DEF,
    parameter int PIN_RESET_CYC = pmc_pkg::PIN_RESET_CYC
) (
    input wire logic i_ref_clk,
    input wire logic i_reset_n,
    input wire logic i_debug_link_clock_pin,
    input wire logic i_debug_link_data_pin,
    output logic o_debug_link_data_pin_out,
    output logic o_debug_link_data_pin_oe,
    output logic o_core_stall,
    output logic o_user_pin_en,
    output logic o_pin_reset_req,
    output logic [15:0] o_mem_addr,
    output logic o_mem_rd,
    input wire logic [7:0] i_mem_data,
    output logic o_cksum_busy
);
    localparam logic [7:0] IDLE_LIM = 8'(pmc_pkg::LINK_IDLE_CYC);
    localparam logic [4:0] FRAME_LAST = 5'(pmc_pkg::FRAME_BITS - 1);
    localparam logic [4:0] FRAME_END = 5'(pmc_pkg::FRAME_BITS);
    localparam logic [4:0] ADDR_LAST = 5'(pmc_pkg::ADDR_BITS_END);
    localparam logic [15:0] RST_LIM = 16'(PIN_RESET_CYC);

    logic ck_s1_ff, ck_s2_ff, ck_d_ff, dt_s1_ff, dt_s2_ff;
    logic [7:0] idle_cnt_ff;
    logic [4:0] bit_cnt_ff;
    logic [15:0] shift_ff;
    logic [7:0] rd_shift_ff;
    logic rd_active_ff;
    logic [7:0] halt_val_ff;
    logic [7:0] cks_ff [4];
    logic [15:0] low_cnt_ff;
    logic rise, fall, idle, wr_commit, rd_start, eng_busy, eng_done, eng_wide;
    logic [7:0] rd_addr;
    logic [31:0] eng_result;
    pmc_pkg::pmc_req_type req;
    pmc_pkg::pmc_cmd_type cmd;

    function automatic logic [7:0] reg_read(input logic [7:0] a, input logic [7:0] hv,
                                            input logic [31:0] c);
        case (a)
            pmc_pkg::ADDR_HALT_CTL: return hv;
            pmc_pkg::ADDR_CKSUM0: return c[7:0];
            pmc_pkg::ADDR_CKSUM1: return c[15:8];
            pmc_pkg::ADDR_CKSUM2: return c[23:16];
            pmc_pkg::ADDR_CKSUM3: return c[31:24];
            default: return pmc_pkg::UNMAPPED_READ;
        endcase
    endfunction : reg_read

    // two-stage synchronisers; only stage two feeds logic
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ck_s1_ff <= 1'b1;
            ck_s2_ff <= 1'b1;
            ck_d_ff <= 1'b1;
            dt_s1_ff <= 1'b0;
            dt_s2_ff <= 1'b0;
        end else begin
            ck_s1_ff <= i_debug_link_clock_pin;
            ck_s2_ff <= ck_s1_ff;
            ck_d_ff <= ck_s2_ff;
            dt_s1_ff <= i_debug_link_data_pin;
            dt_s2_ff <= dt_s1_ff;
        end
    end

    assign rise = ck_s2_ff & ~ck_d_ff;
    assign fall = ~ck_s2_ff & ck_d_ff;
    assign idle = (idle_cnt_ff == IDLE_LIM);

    // clock held high this long ends a frame, so a lost bit cannot wedge the link
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            idle_cnt_ff <= IDLE_LIM;
        end else if (!ck_s2_ff || rise) begin
            idle_cnt_ff <= 8'h00;
        end else if (!idle) begin
            idle_cnt_ff <= idle_cnt_ff + 8'h01;
        end
    end

    // frame shifter sampling on link clock rises
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            bit_cnt_ff <= 5'h00;
            shift_ff <= 16'h0000;
        end else if (idle) begin
            bit_cnt_ff <= 5'h00;
        end else if (rise && bit_cnt_ff != FRAME_END) begin
            shift_ff <= {shift_ff[14:0], dt_s2_ff};
            bit_cnt_ff <= bit_cnt_ff + 5'h01;
        end
    end

    assign req = {shift_ff, dt_s2_ff};
    assign wr_commit = rise && bit_cnt_ff == FRAME_LAST && req.wr;
    assign rd_addr = {shift_ff[6:0], dt_s2_ff};
    // data pin is only driven once halted
    assign rd_start = rise && bit_cnt_ff == ADDR_LAST && !shift_ff[7] && o_core_stall;

    // read answer: one bit per falling edge, host samples on the rise
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rd_shift_ff <= 8'h00;
            rd_active_ff <= 1'b0;
            o_debug_link_data_pin_out <= 1'b0;
            o_debug_link_data_pin_oe <= 1'b0;
        end else if (idle) begin
            rd_active_ff <= 1'b0;
            o_debug_link_data_pin_oe <= 1'b0;
        end else if (rd_start) begin
            rd_shift_ff <= reg_read(rd_addr, halt_val_ff,
                                    {cks_ff[3], cks_ff[2], cks_ff[1], cks_ff[0]});
            rd_active_ff <= 1'b1;
        end else if (fall && rd_active_ff) begin
            if (bit_cnt_ff != FRAME_END) begin
                o_debug_link_data_pin_out <= rd_shift_ff[7];
                rd_shift_ff <= {rd_shift_ff[6:0], 1'b0};
                o_debug_link_data_pin_oe <= 1'b1;
            end else begin
                rd_active_ff <= 1'b0;
                o_debug_link_data_pin_oe <= 1'b0;
            end
        end
    end

    // halted state stalls the core until reset
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_core_stall <= 1'b0;
            o_user_pin_en <= 1'b1;
            halt_val_ff <= pmc_pkg::BYTE_RESET;
        end else if (wr_commit && req.addr == pmc_pkg::ADDR_HALT_CTL) begin
            o_core_stall <= 1'b1;
            o_user_pin_en <= 1'b0;
            halt_val_ff <= req.data;
        end
    end

    // clock pin acts as reset input when not halted
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            low_cnt_ff <= 16'h0000;
            o_pin_reset_req <= 1'b0;
        end else if (ck_s2_ff || o_core_stall) begin
            low_cnt_ff <= 16'h0000;
            o_pin_reset_req <= 1'b0;
        end else if (low_cnt_ff != RST_LIM) begin
            low_cnt_ff <= low_cnt_ff + 16'h0001;
        end else begin
            o_pin_reset_req <= 1'b1;
        end
    end

    // checksum register writes during a run or its done cycle are dropped to keep the result intact
    // block and full start commands
    always_comb begin
        cmd.page = req.data;
        cmd.start_block = wr_commit && o_core_stall && !eng_busy && !eng_done
                          && req.addr == pmc_pkg::ADDR_CKSUM0;
        cmd.start_full = wr_commit && o_core_stall && !eng_busy && !eng_done
                         && req.addr == pmc_pkg::ADDR_CKSUM1;
    end

    // checksum byte registers
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            for (int i = 0; i < 4; i++) begin
                cks_ff[i] <= pmc_pkg::BYTE_RESET;
            end
        end else if (eng_done) begin
            cks_ff[0] <= eng_result[7:0];
            cks_ff[1] <= eng_result[15:8];
            if (eng_wide) begin
                cks_ff[2] <= eng_result[23:16];
                cks_ff[3] <= eng_result[31:24];
            end
        end else if (wr_commit && o_core_stall && !eng_busy) begin
            for (int i = 0; i < 4; i++) begin
                if (req.addr == pmc_pkg::ADDR_CKSUM0 + 8'(i)) begin
                    cks_ff[i] <= req.data;
                end
            end
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_cksum_busy <= 1'b0;
        end else begin
            o_cksum_busy <= eng_busy || cmd.start_block || cmd.start_full;
        end
    end

    pmc_crc_engine #(
        .MEM_BYTES(MEM_BYTES)
    ) u_engine (
        .i_ref_clk(i_ref_clk),
        .i_reset_n(i_reset_n),
        .i_cmd(cmd),
        .i_mem_data(i_mem_data),
        .o_mem_addr(o_mem_addr),
        .o_mem_rd(o_mem_rd),
        .o_busy(eng_busy),
        .o_done(eng_done),
        .o_wide(eng_wide),
        .o_result(eng_result)
    );

    a_block_result: assert property (
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        (eng_done && !eng_wide) |=> cks_ff[1] == $past(eng_result[15:8])
        && cks_ff[0] == $past(eng_result[7:0]) && $stable(cks_ff[3]) && $stable(cks_ff[2]))
        else $error("block result not placed in bytes one and zero");
    a_full_result: assert property (
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        (eng_done && eng_wide) |=> {cks_ff[3], cks_ff[2], cks_ff[1], cks_ff[0]}
        == $past(eng_result))
        else $error("full result not placed across four bytes");
    a_halt_sticky: assert property (
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        o_core_stall |=> o_core_stall && !o_user_pin_en)
        else $error("halt state left without reset");
    a_pin_borrow: assert property (
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        o_debug_link_data_pin_oe |-> o_core_stall)
        else $error("data pin driven while not halted");
    a_reset_pin: assert property (
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        $rose(o_pin_reset_req) |-> !o_core_stall && !$past(ck_s2_ff, 2))
        else $error("pin reset raised while halted or pin high");
    a_halt_entry: assert property (
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        (wr_commit && req.addr == pmc_pkg::ADDR_HALT_CTL) |=> o_core_stall
        && halt_val_ff == $past(req.data))
        else $error("halt control write did not halt");
    a_block_start: assert property (
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        cmd.start_block |=> o_cksum_busy ##[255:300] eng_done)
        else $error("block checksum did not finish in time");

    c_block_done: cover property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        eng_done && !eng_wide);
    c_full_done: cover property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        eng_done && eng_wide);
    c_read_frame: cover property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        rd_start ##[1:200] o_debug_link_data_pin_oe);
    c_halt: cover property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        $rose(o_core_stall));

endmodule : pmc_crc_debug_port

// ==== pmc_host_model.sv ====
// debug host model that clocks frames over the two-wire debug link
// assumes the bench resolves the data wire from the device's enable
`timescale 1ns/1ps
module pmc_host_model (
    input wire logic i_ref_clk,
    input wire logic i_wire,
    output logic o_link_clk,
    output logic o_link_d
);
    // link clock idles high, so it must be high when reset is released
    initial begin
        o_link_clk = 1'b1;
        o_link_d = 1'b1;
    end

    // one bit: 12 cycles low, 13 high makes the 125 ns link period
    task automatic bit_io(input logic b, input logic drive, output logic got);
        @(posedge i_ref_clk);
        o_link_clk <= 1'b0;
        o_link_d <= drive ? b : ~o_link_d; // released line toggles, never holds
        repeat (12) @(posedge i_ref_clk);
        o_link_clk <= 1'b1;
        got = i_wire;
        repeat (12) @(posedge i_ref_clk);
    endtask : bit_io

    // one frame: write flag, address, then data driven or sampled
    task automatic frame(input logic wr, input logic [7:0] addr, input logic [7:0] wdata,
                         output logic [7:0] rdata);
        logic [16:0] bits;
        logic g;
        bits = {wr, addr, wdata};
        for (int i = 16; i >= 0; i--) begin
            bit_io(bits[i], wr || i > 7, g);
            if (i <= 7) rdata[i] = g;
        end
        // 300 ns of clock high closes the frame with margin over 200 ns
        repeat (60) @(posedge i_ref_clk);
    endtask : frame

    task automatic set_clk(input logic v);
        @(posedge i_ref_clk);
        o_link_clk <= v;
    endtask : set_clk
endmodule : pmc_host_model

// ==== pmc_crc_debug_port_test.sv ====
// self-checking bench for the program memory checksum debug port
// assumes MEM_BYTES 512 and PIN_RESET_CYC 50 to keep the run short
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin failures++; \
    $display("ERROR %s expected %h seen %h", nm, exp, got); end end
module pmc_crc_debug_port_test;
    localparam int MEMB = 512;
    logic i_ref_clk, i_reset_n, link_clk, host_d, wire_d, rd_q, oe_seen;
    logic d_out, d_oe, stall, user_en, pin_rst, mem_rd, busy;
    logic [15:0] mem_addr, first_addr;
    logic [7:0] mem_data, rb;
    logic [31:0] exp_crc;
    int failures = 0;
    int checks = 0;

    pmc_crc_debug_port #(.MEM_BYTES(MEMB), .PIN_RESET_CYC(50)) dut (
        .i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_debug_link_clock_pin(link_clk),
        .i_debug_link_data_pin(wire_d), .o_debug_link_data_pin_out(d_out),
        .o_debug_link_data_pin_oe(d_oe), .o_core_stall(stall), .o_user_pin_en(user_en),
        .o_pin_reset_req(pin_rst), .o_mem_addr(mem_addr), .o_mem_rd(mem_rd),
        .i_mem_data(mem_data), .o_cksum_busy(busy));
    pmc_host_model host (.i_ref_clk(i_ref_clk), .i_wire(wire_d), .o_link_clk(link_clk),
        .o_link_d(host_d));
    assign wire_d = d_oe ? d_out : host_d;

    function automatic logic [7:0] mem_fn(input logic [15:0] a);
        return a[7:0] ^ {a[14:8], 1'b1};
    endfunction : mem_fn

    // msb-first checksum, no reflection; upper bits masked for 16-bit runs
    function automatic logic [31:0] crc(input int first, input int n, input logic wide);
        logic [31:0] c;
        logic [7:0] d;
        logic fb;
        c = wide ? pmc_pkg::INIT32_DEF : pmc_pkg::INIT16_DEF;
        for (int i = 0; i < n; i++) begin
            d = mem_fn(16'(first + i));
            for (int b = 7; b >= 0; b--) begin
                fb = (wide ? c[31] : c[15]) ^ d[b];
                c = c << 1;
                if (fb) c = c ^ (wide ? pmc_pkg::POLY32_DEF : pmc_pkg::POLY16_DEF);
            end
        end
        return wide ? c : {16'h0000, c[15:0]};
    endfunction : crc

    // memory with one cycle latency; first address of each run is captured
    always @(posedge i_ref_clk) begin
        mem_data <= mem_fn(mem_addr);
        rd_q <= mem_rd;
        oe_seen <= oe_seen | d_oe;
        if (mem_rd && !rd_q) first_addr <= mem_addr;
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host.frame(1'b1, a, d, rb);
    endtask : wr

    task automatic rd(input logic [7:0] a);
        host.frame(1'b0, a, 8'h00, rb);
    endtask : rd

    task automatic wait_done;
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 3000) begin
            @(posedge i_ref_clk);
            n++;
        end
        `CHK("busy at end", 1'b0, busy)
    endtask : wait_done

    task automatic t_not_halted;
        `CHK("stall at reset", 1'b0, stall)
        rd(pmc_pkg::ADDR_CKSUM0);
        `CHK("drive while running", 1'b0, oe_seen)
        `CHK("user pin owner", 1'b1, user_en)
        // byte 2 write while running must be dropped; the reset-value reads catch it
        wr(pmc_pkg::ADDR_CKSUM2, 8'h11);
        host.set_clk(1'b0);
        repeat (40) @(posedge i_ref_clk);
        `CHK("short low reset", 1'b0, pin_rst)
        repeat (30) @(posedge i_ref_clk);
        `CHK("long low reset", 1'b1, pin_rst)
        host.set_clk(1'b1);
        repeat (70) @(posedge i_ref_clk);
        `CHK("reset released", 1'b0, pin_rst)
        $display("test not_halted done");
    endtask : t_not_halted

    // halt before any program memory work
    task automatic t_halt;
        wr(pmc_pkg::ADDR_HALT_CTL, 8'h5a);
        `CHK("stall after halt", 1'b1, stall)
        `CHK("pin borrowed", 1'b0, user_en)
        host.set_clk(1'b0);
        repeat (70) @(posedge i_ref_clk);
        `CHK("no reset halted", 1'b0, pin_rst)
        rd(pmc_pkg::ADDR_HALT_CTL);
        `CHK("halt byte readback", 8'h5a, rb)
        host.set_clk(1'b1);
        repeat (60) @(posedge i_ref_clk);
        for (int i = 0; i < 4; i++) begin
            rd(pmc_pkg::ADDR_CKSUM0 + 8'(i));
            `CHK("byte reset value", pmc_pkg::BYTE_RESET, rb)
        end
        wr(pmc_pkg::ADDR_CKSUM2, 8'ha5);
        wr(pmc_pkg::ADDR_CKSUM3, 8'h3c);
        rd(pmc_pkg::ADDR_CKSUM2);
        `CHK("byte2 rw", 8'ha5, rb)
        rd(pmc_pkg::ADDR_CKSUM3);
        `CHK("byte3 rw", 8'h3c, rb)
        rd(8'hb0);
        `CHK("unmapped read", pmc_pkg::UNMAPPED_READ, rb)
        $display("test halt done");
    endtask : t_halt

    // host waits for completion before reading
    task automatic t_block(input logic [7:0] page);
        exp_crc = crc(int'({page, 8'h00}), pmc_pkg::BLOCK_BYTES, 1'b0);
        wr(pmc_pkg::ADDR_CKSUM0, page);
        `CHK("block busy", 1'b1, busy)
        wait_done();
        `CHK("block start", {page, pmc_pkg::BLOCK_LOW_FIRST}, first_addr)
        rd(pmc_pkg::ADDR_CKSUM0);
        `CHK("block lsb", exp_crc[7:0], rb)
        rd(pmc_pkg::ADDR_CKSUM1);
        `CHK("block msb", exp_crc[15:8], rb)
        rd(pmc_pkg::ADDR_CKSUM2);
        `CHK("byte2 untouched", 8'ha5, rb)
        $display("test block done");
    endtask : t_block

    task automatic t_full;
        exp_crc = crc(0, MEMB, 1'b1);
        wr(pmc_pkg::ADDR_CKSUM1, 8'h77);
        `CHK("full busy", 1'b1, busy)
        // a start while busy must be ignored, not queued
        wr(pmc_pkg::ADDR_CKSUM0, 8'h01);
        wait_done();
        `CHK("full start", pmc_pkg::MEM_START, first_addr)
        for (int i = 0; i < 4; i++) begin
            rd(pmc_pkg::ADDR_CKSUM0 + 8'(i));
            `CHK("full byte", exp_crc[8 * i +: 8], rb)
        end
        $display("test full done");
    endtask : t_full

    task automatic complete_run;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : complete_run

    initial begin
        i_ref_clk = 1'b0;
        forever #2.5 i_ref_clk = ~i_ref_clk;
    end

    // run needs about 60 us; 400 us means a hang
    initial begin
        #400000;
        failures++;
        complete_run();
    end

    initial begin
        i_reset_n = 1'b0;
        oe_seen = 1'b0;
        mem_data = 8'h00;
        rd_q = 1'b0;
        first_addr = 16'hffff;
        repeat (2) @(posedge i_ref_clk);
        i_reset_n <= 1'b1;
        repeat (4) @(posedge i_ref_clk);
        t_not_halted();
        t_halt();
        t_block(8'h01);
        t_full();
        complete_run();
    end
endmodule : pmc_crc_debug_port_test
